// >>> irq_evt_pkg.sv
/*
 * Shared constants and types for the nested interrupt controller and the
 * edge event controller. Assumes a single 100 MHz system clock domain.
 */
// Function
// - Hardware saves and restores context on exceptions
// - Multi-register transfer abandoned, restarted after entry
// - Vector address is table base plus four times the order number
// - Later higher-priority request dispatched first
// - Tail-chain straight into pending routine on return
// - 32 maskable lines, 4 priority levels
// - Non-maskable input always taken
// - 10 core exception sources share priority scheme
// - Per-channel rising, falling or both edges
// - Channel source from any pin or peripheral
// - Each event channel masked independently
// - Pin pulses shorter than a clock are captured
// - Pending latch holds every event until cleared
package irq_evt_pkg;

    localparam int NUM_IRQ = 32;
    localparam int NUM_EXC = 10;
    localparam int PRIO_W = 2;
    localparam int NUM_SRC = 1 + NUM_EXC + NUM_IRQ;
    localparam int NUM_EVT = 16;
    localparam int NUM_PIN = 16;
    localparam int NUM_PERI = 4;
    localparam int SEL_W = 5;
    localparam int ID_W = 6;
    localparam int ADDR_W = 32;
    // Order numbers: 0 is no source, NMI is 2, core exceptions follow, lines start at 16
    localparam logic [ID_W-1:0] ID_NMI = 6'h02;
    localparam logic [ID_W-1:0] ID_EXC0 = 6'h03;
    localparam logic [ID_W-1:0] ID_IRQ0 = 6'h10;
    localparam logic [ID_W-1:0] ID_NONE = 6'h00;
    localparam logic [ADDR_W-1:0] VTOR_RESET = 32'h0000_0000;
    localparam logic [2:0] VEC_SHIFT = 3'h2;
    localparam logic [PRIO_W:0] PRIO_IDLE = 3'h7;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_BOTH = 2'h2
    } edge_mode_e;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_STACK = 5'h02,
        ST_VECTOR = 5'h04,
        ST_SERVE = 5'h08,
        ST_UNSTACK = 5'h10
    } ctrl_state_e;

endpackage : irq_evt_pkg

// >>> evt_if.sv
/*
 * Carrier between the edge event controller and the interrupt controller.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/10ps
interface evt_if;
    import irq_evt_pkg::*;
    logic [NUM_EVT-1:0] req;
    logic [NUM_EVT-1:0] pending;
    modport src (output req, output pending);
    modport dst (input req, input pending);
endinterface : evt_if

// >>> extended_event_ctrl.sv
/*
 * Edge event channels: source select, edge detection, mask, pending latch.
 * Assumes pin and peripheral inputs are synchronous to clk, plus an
 * asynchronous per-pin capture flag fed by short-pulse catchers.
 */
`timescale 1ns/10ps
module extended_event_ctrl
    import irq_evt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sources
    input wire logic [NUM_PIN-1:0] pin_in,
    input wire logic [NUM_PERI-1:0] peri_in,
    input wire logic [NUM_PIN-1:0] pulse_caught,
    // Configuration
    input wire logic [NUM_EVT*SEL_W-1:0] src_sel,
    input wire logic [NUM_EVT*2-1:0] edge_mode,
    input wire logic [NUM_EVT-1:0] evt_mask,
    input wire logic [NUM_EVT-1:0] pend_clr,
    // Toward the interrupt controller
    evt_if.src evt
);
    typedef struct packed {
        logic [NUM_EVT-1:0] prev;
        logic [NUM_EVT-1:0] pend;
        logic [NUM_EVT-1:0] req;
    } evt_s;

    evt_s cur;
    evt_s next_cur;
    logic [NUM_PIN+NUM_PERI-1:0] all_src;
    logic [NUM_EVT-1:0] lvl;
    logic [NUM_EVT-1:0] hit;

    assign all_src = {peri_in, pin_in};

    // Per-channel source selection and edge detection
    for (genvar i = 0; i < NUM_EVT; i++) begin : g_ch
        logic [SEL_W-1:0] sel;
        logic rise;
        logic fall;
        logic short_pulse;
        assign sel = src_sel[i*SEL_W +: SEL_W];
        assign lvl[i] = (32'(sel) < NUM_PIN + NUM_PERI) ? all_src[sel] : 1'b0;
        assign short_pulse = (32'(sel) < NUM_PIN) ? pulse_caught[sel[3:0]] : 1'b0;
        assign rise = lvl[i] & ~cur.prev[i];
        assign fall = ~lvl[i] & cur.prev[i];
        always_comb begin
            unique case (edge_mode[i*2 +: 2])
                EDGE_RISE: hit[i] = rise | short_pulse;
                EDGE_FALL: hit[i] = fall | short_pulse;
                EDGE_BOTH: hit[i] = rise | fall | short_pulse;
                default: hit[i] = 1'b0;
            endcase
        end
    end

    // Pending latch: a new event beats a clear in the same cycle
    always_comb begin
        next_cur = cur;
        next_cur.prev = lvl;
        next_cur.pend = (cur.pend & ~pend_clr) | hit;
        next_cur.req = next_cur.pend & evt_mask;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign evt.req = cur.req;
    assign evt.pending = cur.pend;
endmodule : extended_event_ctrl

// >>> nested_vector_irq_ctrl.sv
/*
 * Nested vectored interrupt controller with an edge event front end.
 * Arbitrates NMI, core exceptions and 32 lines, drives context save and
 * restore, forms the vector address and tail-chains. Assumes the core
 * acknowledges stack, unstack and vector handshakes with pulses.
 */
`timescale 1ns/10ps
module nested_vector_irq_ctrl
    import irq_evt_pkg::*;
#(
    parameter int IRQ_LINES = NUM_IRQ
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Interrupt sources
    input wire logic nmi_in,
    input wire logic [NUM_EXC-1:0] exc_in,
    input wire logic [IRQ_LINES-1:0] irq_in,
    // Line configuration
    input wire logic [IRQ_LINES-1:0] irq_enable,
    input wire logic [IRQ_LINES*PRIO_W-1:0] irq_prio,
    input wire logic [NUM_EXC*PRIO_W-1:0] exc_prio,
    input wire logic [ADDR_W-1:0] vector_base,
    // Event channel sources and configuration
    input wire logic [NUM_PIN-1:0] pin_in,
    input wire logic [NUM_PERI-1:0] peri_in,
    input wire logic [NUM_PIN-1:0] pulse_caught,
    input wire logic [NUM_EVT*SEL_W-1:0] src_sel,
    input wire logic [NUM_EVT*2-1:0] edge_mode,
    input wire logic [NUM_EVT-1:0] evt_mask,
    input wire logic [NUM_EVT-1:0] pend_clr,
    // Core handshake
    input wire logic multi_busy,
    input wire logic stack_done,
    input wire logic unstack_done,
    input wire logic service_return,
    // Toward the core
    output logic multi_abort,
    output logic stack_req,
    output logic unstack_req,
    output logic vector_valid,
    output logic [ADDR_W-1:0] vector_addr,
    output logic [ID_W-1:0] active_id,
    output logic [NUM_EVT-1:0] evt_pending
);
    typedef struct packed {
        ctrl_state_e state;
        logic [ID_W-1:0] cand;
        logic [ID_W-1:0] act;
        logic [PRIO_W:0] act_prio;
        logic [ADDR_W-1:0] vaddr;
        logic vvalid;
        logic stk;
        logic unstk;
        logic abort;
        logic [NUM_EVT-1:0] pend;
    } ctl_s;

    ctl_s cur;
    ctl_s next_cur;
    evt_if ev();
    logic [IRQ_LINES-1:0] line_req;
    logic [ID_W-1:0] win_id;
    logic [PRIO_W:0] win_prio;

    extended_event_ctrl u_evt (
        .clk(clk),
        .resetn(resetn),
        .pin_in(pin_in),
        .peri_in(peri_in),
        .pulse_caught(pulse_caught),
        .src_sel(src_sel),
        .edge_mode(edge_mode),
        .evt_mask(evt_mask),
        .pend_clr(pend_clr),
        .evt(ev.src)
    );

    // Event channel requests share the low interrupt lines
    always_comb begin
        line_req = irq_in;
        for (int k = 0; k < NUM_EVT && k < IRQ_LINES; k++) begin
            line_req[k] = irq_in[k] | ev.req[k];
        end
    end

    // Arbitration: lowest level value wins, lowest order number breaks ties
    always_comb begin
        win_id = ID_NONE;
        win_prio = PRIO_IDLE;
        for (int j = IRQ_LINES - 1; j >= 0; j--) begin
            if (line_req[j] && irq_enable[j]
                && {1'b0, irq_prio[j*PRIO_W +: PRIO_W]} <= win_prio) begin
                win_prio = {1'b0, irq_prio[j*PRIO_W +: PRIO_W]};
                win_id = ID_IRQ0 + ID_W'(j);
            end
        end
        for (int j = NUM_EXC - 1; j >= 0; j--) begin
            if (exc_in[j] && {1'b0, exc_prio[j*PRIO_W +: PRIO_W]} <= win_prio) begin
                win_prio = {1'b0, exc_prio[j*PRIO_W +: PRIO_W]};
                win_id = ID_EXC0 + ID_W'(j);
            end
        end
        if (nmi_in) begin
            win_prio = '0;
            win_id = ID_NMI;
        end
    end

    // Dispatch sequencing; NMI wins by overriding arbitration and takes level zero
    always_comb begin
        next_cur = cur;
        next_cur.pend = ev.pending;
        next_cur.abort = 1'b0;
        unique case (cur.state)
            ST_RUN: begin
                if (win_id != ID_NONE) begin
                    next_cur.cand = win_id;
                    next_cur.stk = 1'b1;
                    next_cur.abort = multi_busy;
                    next_cur.state = ST_STACK;
                end
            end
            ST_STACK: begin
                if (win_id != ID_NONE) begin
                    next_cur.cand = win_id;
                end
                if (stack_done) begin
                    next_cur.stk = 1'b0;
                    next_cur.state = ST_VECTOR;
                end
            end
            ST_VECTOR: begin
                next_cur.vaddr = vector_base + (ADDR_W'(cur.cand) << VEC_SHIFT);
                next_cur.vvalid = 1'b1;
                next_cur.act = cur.cand;
                next_cur.act_prio = (cur.cand == ID_NMI) ? '0 : win_prio;
                next_cur.state = ST_SERVE;
            end
            ST_SERVE: begin
                next_cur.vvalid = 1'b0;
                if (service_return) begin
                    if (win_id != ID_NONE && win_id != cur.act) begin
                        next_cur.cand = win_id;
                        next_cur.state = ST_VECTOR;
                    end else begin
                        next_cur.unstk = 1'b1;
                        next_cur.state = ST_UNSTACK;
                    end
                end
            end
            ST_UNSTACK: begin
                if (unstack_done) begin
                    next_cur.unstk = 1'b0;
                    next_cur.act = ID_NONE;
                    next_cur.act_prio = PRIO_IDLE;
                    next_cur.state = ST_RUN;
                end
            end
            default: begin
                next_cur.state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cur <= '{state: ST_RUN, cand: ID_NONE, act: ID_NONE, act_prio: PRIO_IDLE,
                     vaddr: VTOR_RESET, vvalid: 1'b0, stk: 1'b0, unstk: 1'b0,
                     abort: 1'b0, pend: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // Every output straight from the state register
    assign multi_abort = cur.abort;
    assign stack_req = cur.stk;
    assign unstack_req = cur.unstk;
    assign vector_valid = cur.vvalid;
    assign vector_addr = cur.vaddr;
    assign active_id = cur.act;
    assign evt_pending = cur.pend;
endmodule : nested_vector_irq_ctrl

// >>> irq_chk_sva.sv
/*
 * Assertion checker for the interrupt controller top ports.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module irq_chk
    import irq_evt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Watched inputs
    input wire logic nmi_in,
    input wire logic multi_busy,
    input wire logic stack_done,
    input wire logic unstack_done,
    input wire logic [ADDR_W-1:0] vector_base,
    // Watched outputs
    input wire logic multi_abort,
    input wire logic stack_req,
    input wire logic unstack_req,
    input wire logic vector_valid,
    input wire logic [ADDR_W-1:0] vector_addr,
    input wire logic [ID_W-1:0] active_id
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_stack_req_holds: assert property (stack_req && !stack_done |=> stack_req)
        else $error("stack request dropped early");
    a_unstack_holds: assert property (unstack_req && !unstack_done |=> unstack_req)
        else $error("unstack request dropped early");
    a_idle_after_restore: assert property (unstack_done |=> active_id == ID_NONE)
        else $error("id kept after restore");
    a_abort_on_busy: assert property ($rose(stack_req) && $past(multi_busy) |-> multi_abort)
        else $error("busy transfer not abandoned");
    a_abort_single: assert property (multi_abort |=> !multi_abort)
        else $error("abort longer than one cycle");
    a_vector_after_stack: assert property (stack_done |-> ##2 vector_valid)
        else $error("vector late after stacking");
    a_vector_addr_form: assert property (vector_valid |-> vector_addr == vector_base + {active_id, 2'b00})
        else $error("vector address wrong");
    a_vector_pulse: assert property (vector_valid |=> !vector_valid)
        else $error("vector strobe too long");
    // The vector slot right after stacking also shows an idle id and no requests
    a_nmi_taken: assert property (nmi_in && active_id == ID_NONE && !stack_req && !unstack_req
        && !$past(stack_done) |=> stack_req)
        else $error("non-maskable request not taken");
endmodule : irq_chk

// >>> core_model.sv
/*
 * Behavioural core answering stack, unstack and vector handshakes.
 * Assumes the controller holds each request until its done pulse.
 */
`timescale 1ns/10ps
module core_model (
    // Clock
    input wire logic clk,
    // Requests
    input wire logic stack_req,
    input wire logic unstack_req,
    input wire logic vector_valid,
    input wire logic [3:0] lag,
    // Answers
    output logic stack_done = 1'b0,
    output logic unstack_done = 1'b0,
    output logic service_return = 1'b0
);
    // Context save takes lag cycles, like a slow stack bus
    always begin
        @(posedge clk);
        if (stack_req) begin
            repeat (lag) @(posedge clk);
            stack_done <= 1'b1;
            @(posedge clk);
            stack_done <= 1'b0;
        end
    end
    // Context restore, same pacing
    always begin
        @(posedge clk);
        if (unstack_req) begin
            repeat (lag) @(posedge clk);
            unstack_done <= 1'b1;
            @(posedge clk);
            unstack_done <= 1'b0;
        end
    end
    // Routine runs long enough for the bench to drop its source
    always begin
        @(posedge clk);
        if (vector_valid) begin
            repeat (lag + 8) @(posedge clk);
            service_return <= 1'b1;
            @(posedge clk);
            service_return <= 1'b0;
        end
    end
endmodule : core_model

// >>> testbench.sv
/*
 * Self-checking bench for the interrupt controller and event channels.
 * Assumes the package, carrier, design and checker compile first.
 */
`timescale 1ns/10ps
module testbench;
    import irq_evt_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, nmi_in = 1'b0, multi_busy = 1'b0, chained;
    logic [3:0] lag = 4'h0, peri_in = 4'h0;
    logic [9:0] exc_in = 10'h000;
    logic [19:0] exc_prio = 20'h00000;
    logic [31:0] irq_in = 32'h0, irq_enable = 32'h0, edge_mode = 32'hffff_ffff, vector_base = 32'h0000_1000;
    logic [63:0] irq_prio = 64'h0;
    logic [79:0] src_sel = 80'h0;
    logic [15:0] pin_in = 16'h0, pulse_caught = 16'h0, evt_mask = 16'h0, pend_clr = 16'h0, evt_pending;
    logic stack_done, unstack_done, service_return, multi_abort, stack_req, unstack_req, vector_valid;
    logic [31:0] vector_addr;
    logic [5:0] active_id;
    int fails = 0, comparisons = 0;

    always #5 clk = ~clk;
    nested_vector_irq_ctrl nested_vector_irq_ctrl_i (.clk(clk), .resetn(resetn), .nmi_in(nmi_in),
        .exc_in(exc_in), .irq_in(irq_in), .irq_enable(irq_enable), .irq_prio(irq_prio), .exc_prio(exc_prio),
        .vector_base(vector_base), .pin_in(pin_in), .peri_in(peri_in), .pulse_caught(pulse_caught),
        .src_sel(src_sel), .edge_mode(edge_mode), .evt_mask(evt_mask), .pend_clr(pend_clr),
        .multi_busy(multi_busy), .stack_done(stack_done), .unstack_done(unstack_done),
        .service_return(service_return), .multi_abort(multi_abort), .stack_req(stack_req),
        .unstack_req(unstack_req), .vector_valid(vector_valid), .vector_addr(vector_addr),
        .active_id(active_id), .evt_pending(evt_pending));
    core_model core_model_i (.clk(clk), .stack_req(stack_req), .unstack_req(unstack_req),
        .vector_valid(vector_valid), .lag(lag), .stack_done(stack_done), .unstack_done(unstack_done),
        .service_return(service_return));
    // Any restore between two vectors breaks a chain
    always @(posedge clk) if (unstack_req) chained <= 1'b0;

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task end_of_test;
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Wait for a vector, judge it, then drop the source as a routine would
    task serve(input logic [5:0] id);
        int n;
        n = 0;
        while (vector_valid !== 1'b1 && n < 300) begin tick(1); n++; end
        if (n >= 300) fails++;
        check(active_id, id);
        check(vector_addr, vector_base + {id, 2'b00});
        @(posedge clk);
        if (id == ID_NMI) nmi_in <= 1'b0;
        else if (id < ID_IRQ0) exc_in[id - ID_EXC0] <= 1'b0;
        else begin irq_in[id - ID_IRQ0] <= 1'b0; pend_clr[id[3:0]] <= 1'b1; end
        @(posedge clk);
        pend_clr <= 16'h0;
    endtask : serve
    task idle;
        int n;
        n = 0;
        while ((active_id !== 6'h00 || unstack_req !== 1'b0) && n < 300) begin tick(1); n++; end
        if (n >= 300) fails++;
        tick(2);
    endtask : idle
    task t_mask;
        int n;
        @(posedge clk); irq_in[5] <= 1'b1; multi_busy <= 1'b1;
        tick(10); check(stack_req, 1'b0);
        @(posedge clk); irq_enable <= 32'hffff_ffff;
        tick(1); check(multi_abort, 1'b1);
        check(stack_req, 1'b1);
        serve(6'h15);
        // Restore must be requested while the served id still stands
        n = 0;
        while (unstack_req !== 1'b1 && n < 300) begin tick(1); n++; end
        check(unstack_req, 1'b1);
        check(active_id, 6'h15);
        idle;
        @(posedge clk); multi_busy <= 1'b0;
    endtask : t_mask
    task t_chain;
        @(posedge clk); lag <= 4'h6; irq_prio[7:6] <= 2'h2; irq_prio[15:14] <= 2'h1; irq_in[3] <= 1'b1;
        tick(2); @(posedge clk); irq_in[7] <= 1'b1;
        serve(6'h17); chained = 1'b1; serve(6'h13);
        check(chained, 1'b1);
        idle; lag <= 4'h0;
    endtask : t_chain
    task t_nmi;
        @(posedge clk); irq_enable <= 32'h0; nmi_in <= 1'b1; exc_in[4] <= 1'b1;
        serve(ID_NMI); serve(6'h07); idle;
        for (int j = 0; j < NUM_EXC; j++) begin @(posedge clk); exc_in[j] <= 1'b1; serve(6'(ID_EXC0 + j)); idle; end
    endtask : t_nmi
    task t_evt(input logic [4:0] src, input logic [1:0] mode, input logic rise, input logic fall);
        @(posedge clk); src_sel[14:10] <= src; edge_mode[5:4] <= mode;
        @(posedge clk); pin_in[9] <= 1'b1; peri_in[1] <= 1'b1;
        tick(4); check(evt_pending[2], rise);
        @(posedge clk); pend_clr[2] <= 1'b1;
        @(posedge clk); pend_clr[2] <= 1'b0; pin_in[9] <= 1'b0; peri_in[1] <= 1'b0;
        tick(4); check(evt_pending[2], fall);
        @(posedge clk); pend_clr[2] <= 1'b1;
        @(posedge clk); pend_clr[2] <= 1'b0;
        tick(3); check(evt_pending[2], 1'b0);
    endtask : t_evt
    task t_latch;
        @(posedge clk); irq_enable[2] <= 1'b1; src_sel[14:10] <= 5'h09; edge_mode[5:4] <= 2'h0;
        @(posedge clk); pulse_caught[9] <= 1'b1;
        @(posedge clk); pulse_caught[9] <= 1'b0;
        tick(6); check(evt_pending[2], 1'b1);
        check(stack_req, 1'b0);
        @(posedge clk); evt_mask[2] <= 1'b1;
        serve(6'h12); idle;
        check(evt_pending[2], 1'b0);
    endtask : t_latch

    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        fails++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_mask; t_chain; t_nmi;
        t_evt(5'h09, 2'h0, 1'b1, 1'b0); t_evt(5'h09, 2'h1, 1'b0, 1'b1);
        t_evt(5'h11, 2'h2, 1'b1, 1'b1); t_evt(5'h09, 2'h3, 1'b0, 1'b0);
        t_latch;
        end_of_test;
    end
endmodule : testbench

bind nested_vector_irq_ctrl irq_chk irq_chk_i (.clk(clk), .resetn(resetn), .nmi_in(nmi_in),
    .multi_busy(multi_busy), .stack_done(stack_done), .unstack_done(unstack_done), .vector_base(vector_base),
    .multi_abort(multi_abort), .stack_req(stack_req), .unstack_req(unstack_req), .vector_valid(vector_valid),
    .vector_addr(vector_addr), .active_id(active_id));
